// ### hdl/isv_vector_ctrl.v
// Interrupt source vectoring: latches requests, picks a winner, hands a vector to the core
`timescale 1ns/1ps
`include "isv_map.vh"
module isv_vector_ctrl #(
  parameter NM = `ISV_NUM_MASKABLE
) (
  input  wire        core_clk_i,                 // System clock
  input  wire        rst_i,                      // Async reset, active high
  input  wire        watchdog_reset_i,           // Internal reset from a watchdog, pulse
  input  wire        pin_nmi_edge_i,             // Valid edge seen on NMI pin, pulse
  input  wire        watchdog_a_nonmaskable_req, // Watchdog A overflow in NMI mode, pulse
  input  wire        watchdog_b_nonmaskable_req, // Watchdog B overflow in NMI mode, pulse
  input  wire        watchdog_a_interval_req,    // Watchdog A overflow in interval mode
  input  wire [6:0]  external_edge_req_i,        // Edge inputs 0..6, pulses
  input  wire        wide_timer_match_a_req,     // Wide timer compare A match
  input  wire        wide_timer_match_b_req,     // Wide timer compare B match
  input  wire        narrow_timer_0_match_req,   // Narrow timer 0 match
  input  wire        narrow_timer_1_match_req,   // Narrow timer 1 match
  input  wire        serial0_rx_error_req,       // Serial 0 receive error
  input  wire        serial0_rx_done_req,        // Serial 0 receive done
  input  wire        serial0_tx_done_req,        // Serial 0 transmit done
  input  wire        serial1_rx_error_req,       // Serial 1 receive error
  input  wire        serial1_rx_done_req,        // Serial 1 receive done
  input  wire        serial1_tx_done_req,        // Serial 1 transmit done
  input  wire        soft_trap_i,                // Trap instruction executed, pulse
  input  wire        soft_trap_group_i,          // 0 soft_trap_group_a, 1 soft_trap_group_b
  input  wire [3:0]  soft_trap_operand_i,        // Trap operand low nibble
  input  wire        int_enable_i,               // Core accepts maskable requests
  input  wire        ack_i,                      // Core takes the offered vector, pulse
  output reg         vec_valid_o,                // Vector offered to core
  output reg  [2:0]  vec_kind_o,                 // Kind of the offered event
  output reg  [15:0] vec_code_o,                 // Exception code
  output reg  [31:0] vec_handler_o,              // Handler address
  output reg  [1:0]  vec_rpc_o,                  // Restored PC policy
  output reg  [4:0]  vec_prio_o,                 // Default priority of a maskable winner
  output reg         reset_vec_o                 // Reset vector taken, pulse
);
  // ============================================================
  // Request latches
  reg  [NM-1:0] mask_pend;
  reg  [2:0]    nmi_pend;   // [2] watchdog B, [1] watchdog A, [0] pin
  reg  [NM-1:0] mask_in;
  wire          mask_any;
  wire [4:0]    mask_idx;
  reg           next_valid;
  reg  [2:0]    next_kind;
  reg  [15:0]   next_code;
  reg  [1:0]    next_rpc;
  reg  [4:0]    next_prio;
  reg  [31:0]   next_handler;
  reg  [NM-1:0] mask_clr;
  reg  [2:0]    nmi_clr;
  wire          offer_free;

  // Request map: each source sits at its default priority index; the gaps
  // at 8, 9, 14 and 15 belong to sources outside this block and stay low
  always @* begin
    mask_in                                        = {NM{1'b0}};
    mask_in[`ISV_PRIO_WDA_INT]                     = watchdog_a_interval_req;
    mask_in[`ISV_PRIO_EDGE_0 +: `ISV_NUM_EDGE]     = external_edge_req_i;
    mask_in[`ISV_PRIO_WIDE_A]                      = wide_timer_match_a_req;
    mask_in[`ISV_PRIO_WIDE_B]                      = wide_timer_match_b_req;
    mask_in[`ISV_PRIO_NARROW_0]                    = narrow_timer_0_match_req;
    mask_in[`ISV_PRIO_NARROW_1]                    = narrow_timer_1_match_req;
    mask_in[`ISV_PRIO_S0_RX_ERR]                   = serial0_rx_error_req;
    mask_in[`ISV_PRIO_S0_RX_DONE]                  = serial0_rx_done_req;
    mask_in[`ISV_PRIO_S0_TX_DONE]                  = serial0_tx_done_req;
    mask_in[`ISV_PRIO_S1_RX_ERR]                   = serial1_rx_error_req;
    mask_in[`ISV_PRIO_S1_RX_DONE]                  = serial1_rx_done_req;
    mask_in[`ISV_PRIO_S1_TX_DONE]                  = serial1_tx_done_req;
  end

  isv_prio_pick #(
    .N  (NM),
    .IW (5)
  ) u_pick (
    .req_i (mask_pend),
    .any_o (mask_any),
    .idx_o (mask_idx)
  );

  // A new offer may be formed when the slot is empty or being taken now
  assign offer_free = !vec_valid_o || ack_i;

  // ============================================================
  // Arbitration: reset, then NMI, then trap, then maskable
  always @* begin
    next_valid = vec_valid_o;
    next_kind  = vec_kind_o;
    next_code  = vec_code_o;
    next_rpc   = vec_rpc_o;
    next_prio  = vec_prio_o;
    mask_clr   = {NM{1'b0}};
    nmi_clr    = 3'b000;
    if (ack_i) begin
      next_valid = 1'b0;
    end
    if (offer_free) begin
      // NMIs ignore int_enable_i and outrank everything but reset; offering a
      // higher NMI drops the lower ones that were pending beside it
      if (nmi_pend[2]) begin
        next_valid = 1'b1;
        next_kind  = `ISV_KIND_NMI;
        next_code  = `ISV_CODE_WDB_NMI;
        next_rpc   = `ISV_RPC_WATCHDOG;
        next_prio  = 5'h00;
        nmi_clr    = 3'b111;
      end else if (nmi_pend[1]) begin
        next_valid = 1'b1;
        next_kind  = `ISV_KIND_NMI;
        next_code  = `ISV_CODE_WDA_NMI;
        next_rpc   = `ISV_RPC_WATCHDOG;
        next_prio  = 5'h00;
        nmi_clr    = 3'b011;
      end else if (nmi_pend[0]) begin
        next_valid = 1'b1;
        next_kind  = `ISV_KIND_NMI;
        next_code  = `ISV_CODE_PIN_NMI;
        next_rpc   = `ISV_RPC_NEXT;
        next_prio  = 5'h00;
        nmi_clr    = 3'b001;
      end else if (soft_trap_i) begin
        // Trap is not latched; it only wins when no NMI is pending
        next_valid = 1'b1;
        next_kind  = `ISV_KIND_TRAP;
        next_code  = (soft_trap_group_i ? `ISV_CODE_TRAP_B : `ISV_CODE_TRAP_A)
                     | {12'h000, soft_trap_operand_i};
        next_rpc   = `ISV_RPC_NEXT;
        next_prio  = 5'h00;
      end else if (mask_any && int_enable_i) begin
        // Maskables wait in their latches while int_enable_i is low
        next_valid = 1'b1;
        next_kind  = `ISV_KIND_MASKABLE;
        next_code  = `ISV_CODE_MASK_BASE
                     + {7'h00, mask_idx, 4'h0};
        next_rpc   = `ISV_RPC_NEXT;
        next_prio  = mask_idx;
        mask_clr[mask_idx] = 1'b1;
      end
    end
  end

  // ============================================================
  // Handler select from the code about to stand. Traps of one group share
  // one entry; every other source follows its own code. Taking the group
  // from the code instead of the live group input keeps a standing trap
  // offer steady while the core has not yet taken it.
  always @* begin
    case (next_kind)
      `ISV_KIND_TRAP: begin
        next_handler = next_code[`ISV_TRAP_GROUP_BIT] ? `ISV_HANDLER_TRAP_B
                                                      : `ISV_HANDLER_TRAP_A;
      end
      `ISV_KIND_RESET: begin
        next_handler = `ISV_HANDLER_RESET;
      end
      default: begin
        next_handler = {16'h0000, next_code};
      end
    endcase
  end

  // ============================================================
  // Pending latches; a fresh request in the clearing cycle survives
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_pend <= {NM{1'b0}};
      nmi_pend  <= 3'b000;
    end else if (watchdog_reset_i) begin
      mask_pend <= {NM{1'b0}};
      nmi_pend  <= 3'b000;
    end else begin
      mask_pend <= (mask_pend & ~mask_clr) | mask_in;
      nmi_pend  <= (nmi_pend & ~nmi_clr)
                   | {watchdog_b_nonmaskable_req, watchdog_a_nonmaskable_req, pin_nmi_edge_i};
    end
  end

  // ============================================================
  // Offer registers; the handler is the zero-extended code, or the group entry for a trap
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vec_valid_o   <= 1'b1;
      vec_kind_o    <= `ISV_KIND_RESET;
      vec_code_o    <= `ISV_CODE_RESET;
      vec_handler_o <= `ISV_HANDLER_RESET;
      vec_rpc_o     <= `ISV_RPC_UNDEF;
      vec_prio_o    <= 5'h00;
      reset_vec_o   <= 1'b0;
    end else if (watchdog_reset_i) begin
      vec_valid_o   <= 1'b1;
      vec_kind_o    <= `ISV_KIND_RESET;
      vec_code_o    <= `ISV_CODE_RESET;
      vec_handler_o <= `ISV_HANDLER_RESET;
      vec_rpc_o     <= `ISV_RPC_UNDEF;
      vec_prio_o    <= 5'h00;
      reset_vec_o   <= 1'b0;
    end else begin
      vec_valid_o   <= next_valid;
      vec_kind_o    <= next_kind;
      vec_code_o    <= next_code;
      vec_rpc_o     <= next_rpc;
      vec_prio_o    <= next_prio;
      // Pulse only when a standing reset offer is really taken
      reset_vec_o   <= ack_i && vec_valid_o && (vec_kind_o == `ISV_KIND_RESET);
      vec_handler_o <= next_handler;
    end
  end
endmodule // isv_vector_ctrl

// ### common/isv_map.vh
// Exception codes, handler bases and priority constants for interrupt source vectoring
`ifndef ISV_MAP_VH
`define ISV_MAP_VH
// ============================================================
// Exception codes
`define ISV_CODE_RESET      16'h0000
`define ISV_CODE_PIN_NMI    16'h0010
`define ISV_CODE_WDA_NMI    16'h0020
`define ISV_CODE_WDB_NMI    16'h0030
`define ISV_CODE_TRAP_A     16'h0040
`define ISV_CODE_TRAP_B     16'h0050
`define ISV_CODE_MASK_BASE  16'h0080
`define ISV_CODE_STEP       16'h0010
// ============================================================
// Handler addresses
`define ISV_HANDLER_RESET   32'h00000000
`define ISV_HANDLER_TRAP_A  32'h00000040
`define ISV_HANDLER_TRAP_B  32'h00000050
// ============================================================
// Source counts and kinds
`define ISV_NUM_MASKABLE    22
`define ISV_KIND_NONE       3'h0
`define ISV_KIND_RESET      3'h1
`define ISV_KIND_NMI        3'h2
`define ISV_KIND_TRAP       3'h3
`define ISV_KIND_MASKABLE   3'h4
// ============================================================
// Restored PC policy
`define ISV_RPC_UNDEF       2'h0
`define ISV_RPC_NEXT        2'h1
`define ISV_RPC_WATCHDOG    2'h2
// ============================================================
// Default priority index of each maskable source kept in this block
`define ISV_PRIO_WDA_INT    0
`define ISV_PRIO_EDGE_0     1
`define ISV_NUM_EDGE        7
`define ISV_PRIO_WIDE_A     10
`define ISV_PRIO_WIDE_B     11
`define ISV_PRIO_NARROW_0   12
`define ISV_PRIO_NARROW_1   13
`define ISV_PRIO_S0_RX_ERR  16
`define ISV_PRIO_S0_RX_DONE 17
`define ISV_PRIO_S0_TX_DONE 18
`define ISV_PRIO_S1_RX_ERR  19
`define ISV_PRIO_S1_RX_DONE 20
`define ISV_PRIO_S1_TX_DONE 21
// ============================================================
// Code bit that tells the two trap groups apart
`define ISV_TRAP_GROUP_BIT  4
`endif

// ### hdl/isv_prio_pick.v
// Fixed-priority picker: lowest index among set request bits wins
`timescale 1ns/1ps
module isv_prio_pick #(
  parameter N  = 22,
  parameter IW = 5
) (
  input  wire [N-1:0]  req_i,   // Request vector, index is default priority
  output reg           any_o,   // At least one request set
  output reg  [IW-1:0] idx_o    // Winning index
);
  integer k;
  // ============================================================
  // Scan from high to low so the lowest index is kept last
  always @* begin
    any_o = 1'b0;
    idx_o = {IW{1'b0}};
    for (k = N - 1; k >= 0; k = k - 1) begin
      if (req_i[k]) begin
        any_o = 1'b1;
        idx_o = k[IW-1:0];
      end
    end
  end
endmodule // isv_prio_pick

// ### verification/isv_vc_props.sv
// Concurrent checks on the vector offer of the vectoring block
`timescale 1ns/1ps
module isv_vc_props (
  input wire        core_clk_i,                 // Clock
  input wire        rst_i,                      // Reset
  input wire        watchdog_reset_i,           // Internal reset
  input wire        pin_nmi_edge_i,             // Pin NMI
  input wire        watchdog_a_nonmaskable_req, // NMI A
  input wire        watchdog_b_nonmaskable_req, // NMI B
  input wire        soft_trap_i,                // Trap
  input wire        soft_trap_group_i,          // Group
  input wire [3:0]  soft_trap_operand_i,        // Operand
  input wire        ack_i,                      // Ack
  input wire        vec_valid_o,                // Offer
  input wire [2:0]  vec_kind_o,                 // Kind
  input wire [15:0] vec_code_o,                 // Code
  input wire [31:0] vec_handler_o,              // Handler
  input wire [1:0]  vec_rpc_o,                  // Restored PC policy
  input wire [4:0]  vec_prio_o,                 // Priority
  input wire        reset_vec_o                 // Reset taken
);
  // ==========
  // Offer checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // A trap in the cycle after any NMI loses its slot, so such cases are left out
  wire nmi_in = pin_nmi_edge_i | watchdog_a_nonmaskable_req | watchdog_b_nonmaskable_req;
  sequence trap_req;
    soft_trap_i && !vec_valid_o && !nmi_in && !$past(nmi_in);
  endsequence
  sequence trap_offer;
    vec_valid_o && vec_kind_o == 3'h3
    && vec_code_o == {8'h00, 3'h2, $past(soft_trap_group_i), $past(soft_trap_operand_i)}
    && vec_handler_o == {24'h000000, 3'h2, $past(soft_trap_group_i), 4'h0};
  endsequence
  rst_offer_a: assert property ($fell(rst_i) |-> vec_valid_o && vec_kind_o == 3'h1
    && vec_code_o == 16'h0000 && vec_handler_o == 32'h00000000) else $error("reset offer");
  rst_taken_a: assert property (vec_valid_o && vec_kind_o == 3'h1 && ack_i |=> reset_vec_o)
    else $error("reset pulse");
  hdl_ext_a: assert property (vec_valid_o && vec_kind_o[2:1] != 2'h0 && vec_kind_o != 3'h3
    |-> vec_handler_o == {16'h0000, vec_code_o}) else $error("handler");
  mask_code_a: assert property (vec_valid_o && vec_kind_o == 3'h4
    |-> vec_code_o == 16'h0080 + {7'h00, vec_prio_o, 4'h0} && vec_prio_o <= 5'h15
    && !(vec_prio_o inside {5'h08, 5'h09, 5'h0E, 5'h0F})) else $error("maskable code");
  nmi_code_a: assert property (vec_valid_o && vec_kind_o == 3'h2
    |-> vec_code_o inside {16'h0010, 16'h0020, 16'h0030}) else $error("nmi code");
  nmi_take_a: assert property (pin_nmi_edge_i && !soft_trap_i ##1 !vec_valid_o
    |=> vec_valid_o && vec_kind_o == 3'h2) else $error("nmi not taken");
  nmi_order_a: assert property (nmi_in && watchdog_a_nonmaskable_req &&
    watchdog_b_nonmaskable_req ##1 !vec_valid_o |=> vec_code_o == 16'h0030) else $error("order");
  trap_vec_a: assert property (trap_req |=> trap_offer) else $error("trap vector");
  wd_rst_offer_a: assert property (watchdog_reset_i |=> vec_valid_o && vec_kind_o == 3'h1
    && vec_code_o == 16'h0000 && vec_handler_o == 32'h00000000 && vec_rpc_o == 2'h0)
    else $error("watchdog reset offer");
  rpc_map_a: assert property (vec_valid_o |-> vec_rpc_o == ((vec_kind_o == 3'h1) ? 2'h0
    : (vec_kind_o == 3'h2 && vec_code_o != 16'h0010) ? 2'h2 : 2'h1)) else $error("restored pc");
  offer_hold_a: assert property (vec_valid_o && !ack_i && !watchdog_reset_i
    |=> vec_valid_o && $stable(vec_kind_o) && $stable(vec_code_o) && $stable(vec_handler_o))
    else $error("offer moved");
endmodule // isv_vc_props
bind isv_vector_ctrl isv_vc_props i_props (.*);

// ### verification/isv_core_model.sv
// Core-side model that takes each offered vector after a set wait
`timescale 1ns/1ps
module isv_core_model (
  input  wire        core_clk_i, // Clock
  input  wire        rst_i,      // Reset
  input  wire        valid_i,    // Offer present
  input  wire [15:0] code_i,     // Offered code
  input  wire        take_i,     // Core willing
  input  wire [3:0]  delay_i,    // Wait before ack
  output reg         ack_o,      // Ack pulse
  output reg  [15:0] code_o,     // Taken code
  output reg  [7:0]  cnt_o       // Offers taken
);
  reg [3:0] wait_cnt;
  // ==========
  // Ack lasts one cycle and the wait restarts, so back-to-back offers are paced too
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wait_cnt <= 4'h0;
      cnt_o <= 8'h00;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      wait_cnt <= 4'h0;
      cnt_o <= cnt_o + 8'h01;
      code_o <= code_i;
    end else if (valid_i && take_i) begin
      if (wait_cnt == delay_i) ack_o <= 1'b1;
      else wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // isv_core_model

// ### verification/tb.sv
// Self-checking bench for the interrupt source vectoring block
`timescale 1ns/1ps
module tb;
  reg         core_clk_i = 1'b0, rst_i = 1'b1, wd_rst = 1'b0, trap = 1'b0, grp = 1'b0;
  reg         ien = 1'b0, take = 1'b1;
  reg  [21:0] mreq = 22'h000000;
  reg  [2:0]  nmi = 3'h0;
  reg  [3:0]  opnd = 4'h0, dly = 4'h0;
  wire        ack, vld;
  wire [15:0] code, t_code;
  wire [7:0]  t_cnt;
  integer     n_errors = 0, check_count = 0, i, k;
  // ==========
  // Clock, design and core model
  always #2 core_clk_i = ~core_clk_i;
  isv_vector_ctrl i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .watchdog_reset_i(wd_rst),
    .pin_nmi_edge_i(nmi[0]), .watchdog_a_nonmaskable_req(nmi[1]),
    .watchdog_b_nonmaskable_req(nmi[2]), .watchdog_a_interval_req(mreq[0]),
    .external_edge_req_i(mreq[7:1]), .wide_timer_match_a_req(mreq[10]),
    .wide_timer_match_b_req(mreq[11]), .narrow_timer_0_match_req(mreq[12]),
    .narrow_timer_1_match_req(mreq[13]), .serial0_rx_error_req(mreq[16]),
    .serial0_rx_done_req(mreq[17]), .serial0_tx_done_req(mreq[18]),
    .serial1_rx_error_req(mreq[19]), .serial1_rx_done_req(mreq[20]),
    .serial1_tx_done_req(mreq[21]), .soft_trap_i(trap), .soft_trap_group_i(grp),
    .soft_trap_operand_i(opnd), .int_enable_i(ien), .ack_i(ack), .vec_valid_o(vld),
    .vec_kind_o(), .vec_code_o(code), .vec_handler_o(), .vec_rpc_o(), .vec_prio_o(),
    .reset_vec_o());
  isv_core_model i_core (.core_clk_i(core_clk_i), .rst_i(rst_i), .valid_i(vld),
    .code_i(code), .take_i(take), .delay_i(dly), .ack_o(ack), .code_o(t_code), .cnt_o(t_cnt));
  task tick;
    begin
      @(posedge core_clk_i);
      #1;
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task check(input string nm, input [15:0] exp, input [15:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  // Bounded wait for the core to take one offer, then judge its code
  task take_one(input [15:0] c);
    reg [7:0] c0;
    begin
      c0 = t_cnt;
      for (k = 0; k < 80 && t_cnt === c0; k = k + 1) tick;
      if (t_cnt === c0) begin
        n_errors = n_errors + 1;
        $display("[ERR] take exp %h got none", c);
        wrap_up;
      end
      check("code", c, t_code);
    end
  endtask
  // ==========
  // Scenarios: reset offers, each maskable, priority, NMIs, traps
  task t_reset;
    begin
      take_one(16'h0000);
      wd_rst = 1'b1;
      tick;
      wd_rst = 1'b0;
      take_one(16'h0000);
    end
  endtask
  task t_mask;
    begin
      ien = 1'b1;
      for (i = 0; i < 22; i = i + 1) begin
        if (i != 8 && i != 9 && i != 14 && i != 15) begin
          mreq[i] = 1'b1;
          tick;
          mreq = 22'h000000;
          take_one(16'h0080 + 16'(16 * i));
        end
      end
    end
  endtask
  // Held off while disabled; an early offer would break the order seen
  task t_prio;
    begin
      ien = 1'b0;
      mreq = 22'h200088;
      tick;
      mreq = 22'h000000;
      repeat (4) tick;
      ien = 1'b1;
      take_one(16'h00B0);
      take_one(16'h00F0);
      take_one(16'h01D0);
    end
  endtask
  task t_nmi;
    begin
      dly = 4'h3;
      ien = 1'b0;
      mreq[0] = 1'b1;
      nmi = 3'h7;
      tick;
      mreq = 22'h000000;
      nmi = 3'h0;
      take_one(16'h0030);
      ien = 1'b1;
      take_one(16'h0080);
      for (i = 0; i < 3; i = i + 1) begin
        nmi[i] = 1'b1;
        tick;
        nmi = 3'h0;
        take_one(16'(16 * (i + 1)));
      end
      dly = 4'h0;
    end
  endtask
  // Group input flips while each trap offer stands; the offer must not follow it
  task t_trap;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        grp = i[1];
        opnd = {4{i[0]}};
        trap = 1'b1;
        tick;
        trap = 1'b0;
        grp = ~grp;
        take_one({8'h00, 3'h2, ~grp, opnd});
      end
    end
  endtask
  initial begin
    repeat (3) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    t_reset;
    t_mask;
    t_prio;
    t_nmi;
    t_trap;
    wrap_up;
  end
endmodule // tb
